// file: hle_link_b_error_log.sv
// Purpose: error logs and message enables for the second hub link
// Assumes: one clock; rst is the power-up reset; evt inputs are core-clock pulses
// Notes:   configuration reads answer one cycle after the read strobe
//
// Operation
// R1: errors after the first logged one land in the next-error log, several bits may be set.
// R2: the first-error log holds a single flag and takes no new one until it is empty.
// R3: writing one to a flag bit clears it, writing zero leaves it alone.
// R4: bit 6 records a system error received from the far end of the link.
// R5: bit 5 records an invalid request address that will be master-aborted, abort sent or not.
// R6: bit 4 records a target-abort completion on a cycle this device started.
// R7: bit 3 records a single-bit correctable header or address error, even with correction off.
// R8: bit 2 records a single-bit correctable data error, even with correction off.
// R9: bit 1 records a multi-bit uncorrectable header or address error, even with correction off.
// R10: bit 0 records a multi-bit uncorrectable data error, even with correction off.
// R11: an enabled bit 0 to 5 raises a system-error message when set in either log.
// R12: a zero enable gives no system-error message, and all enables reset to zero.
// R13: each flag can raise system error (bits 0 to 5 only), management interrupt or config interrupt by its enable.
// R14: software enables at most one message type per flag.
// R15: the first-error log sits at 80h with the same layout, sticky and write-one-to-clear.
// R16: reserved bits read zero and ignore writes, so bit 6 has no system-error enable.
// R17: the flags survive platform resets and clear only on power-up or a write of one.
`timescale 1ns/10ps
module hle_link_b_error_log
    import hle_pkg::*;
(
    // clock and resets
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              platRst,
    // configuration access
    input  wire logic [7:0]        cfgAddr,
    input  wire logic              cfgWr,
    input  wire logic              cfgRd,
    input  wire logic [7:0]        cfgWdata,
    output logic      [7:0]        cfgRdata,
    // error events, one bit per flag
    input  wire logic [NUM_EVT-1:0] errEvt,
    // messages
    output logic                   serrMsg,
    output logic                   mgmtIrq,
    output logic                   cfgIrq
);
    logic [NUM_EVT-1:0] firstFlags;
    logic [NUM_EVT-1:0] nextFlags;
    logic [NUM_EVT-1:0] setFirst;
    logic [NUM_EVT-1:0] setNext;
    logic [NUM_EVT-1:0] clrFirst;
    logic [NUM_EVT-1:0] clrNext;
    logic [7:0]         serrEn_r;
    logic [7:0]         mgmtEn_r;
    logic [7:0]         cfgiEn_r;
    logic [7:0]         rdMux;
    logic [7:0]         anyFlag;
    logic               firstEmpty;
    logic [NUM_EVT-1:0] firstPick;

    assign firstEmpty = (firstFlags == '0);

    // lowest numbered simultaneous event takes the first-error slot
    always_comb
    begin
        firstPick = '0;
        for (int i = NUM_EVT-1; i >= 0; i--)
        begin
            if (errEvt[i])
            begin
                firstPick    = '0;
                firstPick[i] = 1'b1;
            end
        end
    end

    assign setFirst = firstEmpty ? firstPick : '0;             // R2 R15
    assign setNext  = errEvt & ~setFirst;                      // R1 R4 R5 R6 R7 R8 R9 R10
    assign clrFirst = (cfgWr && cfgAddr == OFS_FIRST_ERR)
                      ? cfgWdata[NUM_EVT-1:0] : '0;           // R3
    assign clrNext  = (cfgWr && cfgAddr == OFS_NEXT_ERR)
                      ? cfgWdata[NUM_EVT-1:0] : '0;           // R3

    // flags run on the power-up reset only so they ride through platform resets
    for (genvar g = 0; g < NUM_EVT; g++)
    begin : gFlag
        hle_w1c_flag uFlag
        (
            .clock    (clock),
            .rst      (rst),                                   // R17
            .setFirst (setFirst[g]),
            .setNext  (setNext[g]),
            .clrFirst (clrFirst[g]),
            .clrNext  (clrNext[g]),
            .first_r  (firstFlags[g]),
            .next_r   (nextFlags[g])
        );
    end

    // system-error and management enables are not sticky: platform reset clears them too
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            serrEn_r <= EN_RST;                                // R12
        else if (platRst)
            serrEn_r <= EN_RST;
        else if (cfgWr && cfgAddr == OFS_SERR_EN)
            serrEn_r <= cfgWdata & SERR_EN_MASK;               // R16
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mgmtEn_r <= EN_RST;
        else if (platRst)
            mgmtEn_r <= EN_RST;
        else if (cfgWr && cfgAddr == OFS_MGMT_EN)
            mgmtEn_r <= cfgWdata & IRQ_EN_MASK;
    end

    // config interrupt enables are sticky like the flags
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cfgiEn_r <= EN_RST;
        else if (cfgWr && cfgAddr == OFS_CFGI_EN)
            cfgiEn_r <= cfgWdata & IRQ_EN_MASK;
    end

    assign anyFlag = {1'b0, firstFlags | nextFlags};

    // no arbitration among message types; software keeps them exclusive
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            serrMsg <= 1'b0;
            mgmtIrq <= 1'b0;
            cfgIrq  <= 1'b0;
        end
        else
        begin
            serrMsg <= |(anyFlag & serrEn_r);                  // R11 R12 R13
            mgmtIrq <= |(anyFlag & mgmtEn_r);                  // R13 R14
            cfgIrq  <= |(anyFlag & cfgiEn_r);                  // R13
        end
    end

    always_comb
    begin
        case (cfgAddr)
            OFS_FIRST_ERR: rdMux = {1'b0, firstFlags} & FLAG_MASK;
            OFS_NEXT_ERR:  rdMux = {1'b0, nextFlags} & FLAG_MASK;  // R16
            OFS_SERR_EN:   rdMux = serrEn_r;
            OFS_MGMT_EN:   rdMux = mgmtEn_r;
            OFS_CFGI_EN:   rdMux = cfgiEn_r;
            default:       rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cfgRdata <= 8'h00;
        else if (cfgRd)
            cfgRdata <= rdMux;
    end

    // with the first log empty an event lands there instead, so these wait for it to be taken
    a_next_sets: assert property (@(posedge clock) disable iff (rst) // R4
        (errEvt[BIT_RX_SERR] && !firstEmpty) |=> nextFlags[BIT_RX_SERR])
        else $error("received system error not logged in next log");
    a_inv_addr: assert property (@(posedge clock) disable iff (rst) // R5
        (errEvt[BIT_INV_ADDR] && !firstEmpty) |=> nextFlags[BIT_INV_ADDR])
        else $error("invalid address not logged");
    a_tgt_abort: assert property (@(posedge clock) disable iff (rst) // R6
        (errEvt[BIT_TGT_ABORT] && !firstEmpty) |=> nextFlags[BIT_TGT_ABORT])
        else $error("target abort not logged");
    a_ecc_next: assert property (@(posedge clock) disable iff (rst) // R7 R8 R9 R10
        (|errEvt[BIT_CE_HDR:BIT_UE_DATA] && !firstEmpty)
        |=> ((nextFlags[3:0] & $past(errEvt[3:0])) == $past(errEvt[3:0])))
        else $error("ecc error not logged");
    a_first_single: assert property (@(posedge clock) disable iff (rst) // R2
        $onehot0(firstFlags))
        else $error("first log holds more than one flag");
    a_first_hold: assert property (@(posedge clock) disable iff (rst) // R15
        (!firstEmpty && clrFirst == '0) |=> $stable(firstFlags))
        else $error("first log changed while occupied");
    a_w1c_clear: assert property (@(posedge clock) disable iff (rst) // R3
        (clrNext[BIT_UE_DATA] && !setNext[BIT_UE_DATA]) |=> !nextFlags[BIT_UE_DATA])
        else $error("write one did not clear flag");
    a_w0_keep: assert property (@(posedge clock) disable iff (rst) // R3
        (nextFlags[BIT_UE_HDR] && !clrNext[BIT_UE_HDR]) |=> nextFlags[BIT_UE_HDR])
        else $error("flag lost without a clear");
    a_serr_gate: assert property (@(posedge clock) disable iff (rst) // R11
        (|((firstFlags[NUM_SERR-1:0] | nextFlags[NUM_SERR-1:0]) & serrEn_r[NUM_SERR-1:0]))
        |=> serrMsg)
        else $error("enabled flag gave no system error message");
    a_serr_rsvd: assert property (@(posedge clock) disable iff (rst) // R16
        serrEn_r[7:6] == 2'b00)
        else $error("reserved enable bits set");
    a_plat_keep: assert property (@(posedge clock) disable iff (rst) // R17
        (platRst && nextFlags[BIT_CE_DATA] && !clrNext[BIT_CE_DATA])
        |=> nextFlags[BIT_CE_DATA])
        else $error("flag lost on platform reset");

    // slot, quiet outputs, enables on platform reset and reserved read bits
    a_first_set: assert property (@(posedge clock) disable iff (rst) // R2
        (firstEmpty && |errEvt) |=> !firstEmpty)
        else $error("event with empty first log not logged there");
    a_serr_quiet: assert property (@(posedge clock) disable iff (rst) // R12
        (((firstFlags[NUM_SERR-1:0] | nextFlags[NUM_SERR-1:0]) & serrEn_r[NUM_SERR-1:0]) == '0)
        |=> !serrMsg)
        else $error("system error message without an enabled flag");
    a_mgmt_gate: assert property (@(posedge clock) disable iff (rst) // R13
        ((anyFlag & mgmtEn_r) == 8'h00) |=> !mgmtIrq)
        else $error("management interrupt without an enabled flag");
    a_cfgi_gate: assert property (@(posedge clock) disable iff (rst) // R13
        ((anyFlag & cfgiEn_r) == 8'h00) |=> !cfgIrq)
        else $error("config interrupt without an enabled flag");
    a_plat_enables: assert property (@(posedge clock) disable iff (rst) // R12
        platRst |=> (serrEn_r == EN_RST && mgmtEn_r == EN_RST))
        else $error("platform reset left an enable set");
    a_rsvd_read: assert property (@(posedge clock) disable iff (rst) // R16
        (cfgRd && (cfgAddr == OFS_FIRST_ERR || cfgAddr == OFS_NEXT_ERR)) |=> !cfgRdata[7])
        else $error("reserved log bit read as one");
endmodule : hle_link_b_error_log

// file: hle_link_b_error_log_tb_top.sv
// Purpose: self-checking bench for the link error logs and message enables
// Assumes: byte config access, events from the partner model
// Notes:   logs are cleared between table rows so every row starts empty
`timescale 1ns/10ps
module hle_link_b_error_log_tb_top
    import hle_pkg::*;
();
    typedef struct packed {logic [7:0] evt; logic [7:0] en; logic [7:0] fst;
        logic [7:0] nxt; logic serr;} hle_row_t;
    logic       clock, rst, platRst, cfgWr, cfgRd, serrMsg, mgmtIrq, cfgIrq;
    logic [7:0] cfgAddr, cfgWdata, cfgRdata;
    logic [6:0] fire, errEvt;
    int         nMismatch = 0;
    int         nTests    = 0;
    hle_row_t   rows [5]  = '{'{8'h01, 8'h01, 8'h01, 8'h00, 1'b1},
        '{8'h40, 8'hFF, 8'h40, 8'h00, 1'b0}, '{8'h30, 8'h00, 8'h10, 8'h20, 1'b0},
        '{8'h0C, 8'h08, 8'h04, 8'h08, 1'b1}, '{8'h02, 8'h00, 8'h02, 8'h00, 1'b0}};

    hle_link_b_error_log dut_u (.clock(clock), .rst(rst), .platRst(platRst),
        .cfgAddr(cfgAddr), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata), .errEvt(errEvt), .serrMsg(serrMsg), .mgmtIrq(mgmtIrq),
        .cfgIrq(cfgIrq));
    hle_link_partner far_u (.clock(clock), .rst(rst), .fire(fire), .errEvt(errEvt));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chkByte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chkByte

    task automatic chkBit(input string nm, input logic exp, input logic got);
        nTests++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask : chkBit

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 cfgAddr = a; cfgWdata = d; cfgWr = 1'b1;
        @(posedge clock);
        #1 cfgWr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clock);
        #1 cfgAddr = a; cfgRd = 1'b1;
        @(posedge clock);
        #1 cfgRd = 1'b0;
        chkByte(nm, exp, cfgRdata);
    endtask : rd

    // partner pulse, then flag and message registers settle
    task automatic evt(input logic [7:0] v);
        @(posedge clock);
        #1 fire = v[6:0];
        @(posedge clock);
        #1 fire = 7'h00;
        repeat (3) @(posedge clock);
        #1;
    endtask : evt

    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : giveVerdict

    initial
    begin
        #60000;
        nMismatch++;
        giveVerdict();
    end

    initial
    begin
        rst = 1'b1; platRst = 1'b0; cfgWr = 1'b0; cfgRd = 1'b0;
        cfgAddr = 8'h00; cfgWdata = 8'h00; fire = 7'h00;
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        rd(OFS_FIRST_ERR, 8'h00, "first log reset");
        rd(OFS_NEXT_ERR, 8'h00, "next log reset");
        rd(OFS_SERR_EN, 8'h00, "serr enable reset");
        chkBit("serr idle", 1'b0, serrMsg);
        foreach (rows[i])
        begin
            wr(OFS_SERR_EN, rows[i].en);
            evt(rows[i].evt);
            rd(OFS_FIRST_ERR, rows[i].fst, "first log");
            rd(OFS_NEXT_ERR, rows[i].nxt, "next log");
            chkBit("serr msg", rows[i].serr, serrMsg);
            rd(OFS_SERR_EN, rows[i].en & 8'h3F, "serr enable");
            wr(OFS_FIRST_ERR, 8'h7F);
            wr(OFS_NEXT_ERR, 8'h7F);
        end
        evt(8'h10);
        evt(8'h08);
        rd(OFS_NEXT_ERR, 8'h08, "later error");
        wr(OFS_FIRST_ERR, 8'h00);
        rd(OFS_FIRST_ERR, 8'h10, "zero write");
        wr(OFS_NEXT_ERR, 8'h80);
        rd(OFS_NEXT_ERR, 8'h08, "reserved write");
        evt(8'h76);
        rd(OFS_NEXT_ERR, 8'h7E, "next while first held");
        wr(OFS_NEXT_ERR, 8'h70);
        rd(OFS_NEXT_ERR, 8'h0E, "partial clear");
        // one message type per flag, as software must keep it
        wr(OFS_MGMT_EN, 8'h08);
        wr(OFS_CFGI_EN, 8'h10);
        settle();
        chkBit("mgmt irq", 1'b1, mgmtIrq);
        chkBit("cfg irq", 1'b1, cfgIrq);
        @(posedge clock);
        #1 platRst = 1'b1;
        @(posedge clock);
        #1 platRst = 1'b0;
        rd(OFS_FIRST_ERR, 8'h10, "flag after plat reset");
        rd(OFS_NEXT_ERR, 8'h0E, "next after plat reset");
        rd(OFS_MGMT_EN, 8'h00, "mgmt enable plat reset");
        rd(OFS_CFGI_EN, 8'h10, "cfg enable plat reset");
        chkBit("cfg irq kept", 1'b1, cfgIrq);
        wr(OFS_FIRST_ERR, 8'h10);
        settle();
        rd(OFS_FIRST_ERR, 8'h00, "one write clears");
        chkBit("cfg irq cleared", 1'b0, cfgIrq);
        wr(8'h90, 8'hFF);
        rd(8'h90, 8'h00, "unmapped");
        // power-up reset in mid-run is the only reset that wipes the sticky state
        @(posedge clock);
        #1 rst = 1'b1;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        rd(OFS_NEXT_ERR, 8'h00, "next after power reset");
        rd(OFS_CFGI_EN, 8'h00, "cfg enable power reset");
        chkBit("mgmt irq reset", 1'b0, mgmtIrq);
        giveVerdict();
    end
endmodule : hle_link_b_error_log_tb_top

// file: hle_link_partner.sv
// Purpose: far-end bridge model that raises link error events
// Assumes: fire is driven just after a rising edge, one cycle long
// Notes:   every event reaches the log as a one-cycle pulse
`timescale 1ns/10ps
module hle_link_partner
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // bench command and link events
    input  wire logic [6:0] fire,
    output logic      [6:0] errEvt
);
    // registered so events always land off the bench's own edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            errEvt <= 7'h00;
        else
            errEvt <= fire;
    end
endmodule : hle_link_partner

// file: hle_pkg.sv
// Purpose: constants for the second hub link error log and system-error enable bank
// Assumes: byte-wide configuration access, byte address on the port
// Notes:   flag layout shared by the first-error and next-error logs
package hle_pkg;
    localparam int         FLAG_W        = 8;
    localparam int         NUM_EVT       = 7;
    localparam int         NUM_SERR      = 6;
    localparam logic [7:0] OFS_FIRST_ERR = 8'h80;
    localparam logic [7:0] OFS_NEXT_ERR  = 8'h82;
    localparam logic [7:0] OFS_SERR_EN   = 8'hA0;
    localparam logic [7:0] OFS_MGMT_EN   = 8'hA2;
    localparam logic [7:0] OFS_CFGI_EN   = 8'hA4;
    localparam logic [7:0] FLAG_RST      = 8'h00;
    localparam logic [7:0] FLAG_MASK     = 8'h7F;
    localparam logic [7:0] SERR_EN_MASK  = 8'h3F;
    localparam logic [7:0] IRQ_EN_MASK   = 8'h7F;
    localparam logic [7:0] EN_RST        = 8'h00;
    localparam int         BIT_RX_SERR   = 6;
    localparam int         BIT_INV_ADDR  = 5;
    localparam int         BIT_TGT_ABORT = 4;
    localparam int         BIT_CE_HDR    = 3;
    localparam int         BIT_CE_DATA   = 2;
    localparam int         BIT_UE_HDR    = 1;
    localparam int         BIT_UE_DATA   = 0;
endpackage : hle_pkg

// file: hle_w1c_flag.sv
// Purpose: one sticky write-one-to-clear error flag pair (first and next log)
// Assumes: events and writes on the core clock
// Notes:   cleared only by power-up reset or a write of one
`timescale 1ns/10ps
module hle_w1c_flag
(
    // clock and power-up reset
    input  wire logic clock,
    input  wire logic rst,
    // event and clears
    input  wire logic setFirst,
    input  wire logic setNext,
    input  wire logic clrFirst,
    input  wire logic clrNext,
    // state
    output logic      first_r,
    output logic      next_r
);
    // set wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            first_r <= 1'b0;
        else if (setFirst)
            first_r <= 1'b1;
        else if (clrFirst)
            first_r <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            next_r <= 1'b0;
        else if (setNext)
            next_r <= 1'b1;
        else if (clrNext)
            next_r <= 1'b0;
    end
endmodule : hle_w1c_flag
